// >>> design/irq_level_pkg.sv
package irq_level_pkg;

	// register byte addresses on the special-function-register bus
	localparam logic [15:0] BYTE_TIMER_LEVELS_ADDR = 16'hf02c;
	localparam logic [15:0] FAST_TIMER_LEVELS_ADDR = 16'hf02e;
	localparam logic [15:0] TIME_BASE_LEVELS_ADDR  = 16'hf030;

	localparam logic [15:0] LEVELS_RESET = 16'h0000;

	// writable bits of each register
	localparam logic [15:0] BYTE_TIMER_MASK = 16'hffff;
	localparam logic [15:0] FAST_TIMER_MASK = 16'h00ff;
	localparam logic [15:0] TIME_BASE_MASK  = 16'h003f;

	localparam int LEVEL_W      = 2;
	localparam int NUM_BYTE_TMR = 8;
	localparam int NUM_FAST_TMR = 4;
	localparam int NUM_TICK     = 3;
	localparam int NUM_SRC      = NUM_BYTE_TMR + NUM_FAST_TMR + NUM_TICK;
	localparam int SRC_W        = 4;

	typedef logic [LEVEL_W-1:0] level_t;

	// one special-function-register access
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [1:0]  byte_en;
		logic [15:0] wdata;
	} sfr_req_t;

	// winner of arbitration
	typedef struct packed {
		logic       valid;
		logic [3:0] src;
		level_t     level;
	} irq_grant_t;

endpackage

// >>> design/level_arbiter.sv
`timescale 1ns/1ps
`default_nettype none

module level_arbiter
	import irq_level_pkg::*;
(
	input  wire logic [NUM_SRC-1:0]         pending,
	input  wire logic [NUM_SRC*LEVEL_W-1:0] levels,
	output irq_grant_t                      grant
);

	always_comb begin
		grant = '0;
		// lowest index wins a tie because only a strictly greater level replaces
		for (int i = 0; i < NUM_SRC; i++) begin
			if (pending[i] && (!grant.valid ||
					levels[i*LEVEL_W +: LEVEL_W] > grant.level)) begin
				grant.valid = 1'b1;
				grant.src   = SRC_W'(i);
				grant.level = levels[i*LEVEL_W +: LEVEL_W];
			end
		end
	end

endmodule

`default_nettype wire

// >>> design/timer_irq_priority_levels.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - each field: 00 level one up to 11 level four; resets to level one
// - writes take effect only while level_control_enable is set
// - a pending source with a greater level value wins arbitration
// - byte timer fields 1..7 sit at bits 3:2 up to 15:14
// - wide timer 0..3 fields in bits 7:0; upper byte has no function
// - slow tick 0..2 fields in bits 5:0; bits 15:6 have no function
// - byte or halfword access per register; every register resets to zero
// - byte timer 0 field sits at bits 1:0
module timer_irq_priority_levels
	import irq_level_pkg::*;
(
	input  wire logic                   ref_clk,
	input  wire logic                   rst,
	input  wire sfr_req_t               sfr_req,
	input  wire logic                   level_control_enable,
	input  wire logic [NUM_BYTE_TMR-1:0] byte_timer_irq,
	input  wire logic [NUM_FAST_TMR-1:0] wide_timer_irq,
	input  wire logic [NUM_TICK-1:0]    slow_tick_irq,
	output logic [15:0]                 sfr_rdata,
	output logic [15:0]                 byte_timer_irq_levels,
	output logic [15:0]                 fast_timer_irq_levels,
	output logic [15:0]                 time_base_irq_levels,
	output irq_grant_t                  irq_grant
);

	logic [15:0] next_byte_timer_irq_levels;
	logic [15:0] next_fast_timer_irq_levels;
	logic [15:0] next_time_base_irq_levels;
	logic [15:0] next_sfr_rdata;
	irq_grant_t  next_irq_grant;
	irq_grant_t  arb_grant;

	// merge enabled byte lanes into a register, keeping bits without function at zero
	function automatic logic [15:0] lane_write(input logic [15:0] cur,
			input logic [15:0] wdata, input logic [1:0] be, input logic [15:0] mask);
		logic [15:0] lanes;
		lanes = {{8{be[1]}}, {8{be[0]}}};
		return ((cur & ~lanes) | (wdata & lanes)) & mask;
	endfunction

	always_comb begin
		next_byte_timer_irq_levels = byte_timer_irq_levels;
		next_fast_timer_irq_levels = fast_timer_irq_levels;
		next_time_base_irq_levels  = time_base_irq_levels;
		if (sfr_req.wr && level_control_enable) begin
			unique case (sfr_req.addr)
				BYTE_TIMER_LEVELS_ADDR: next_byte_timer_irq_levels = lane_write(
					byte_timer_irq_levels, sfr_req.wdata, sfr_req.byte_en,
					BYTE_TIMER_MASK);
				FAST_TIMER_LEVELS_ADDR: next_fast_timer_irq_levels = lane_write(
					fast_timer_irq_levels, sfr_req.wdata, sfr_req.byte_en,
					FAST_TIMER_MASK);
				TIME_BASE_LEVELS_ADDR: next_time_base_irq_levels = lane_write(
					time_base_irq_levels, sfr_req.wdata, sfr_req.byte_en,
					TIME_BASE_MASK);
				default: ;
			endcase
		end
	end

	always_comb begin
		next_sfr_rdata = 16'h0000;
		if (sfr_req.rd) begin
			unique case (sfr_req.addr)
				BYTE_TIMER_LEVELS_ADDR: next_sfr_rdata = byte_timer_irq_levels;
				FAST_TIMER_LEVELS_ADDR: next_sfr_rdata = fast_timer_irq_levels;
				TIME_BASE_LEVELS_ADDR:  next_sfr_rdata = time_base_irq_levels;
				default:                next_sfr_rdata = 16'h0000;
			endcase
		end
	end

	level_arbiter u_arb (
		.pending ({slow_tick_irq, wide_timer_irq, byte_timer_irq}),
		.levels  ({time_base_irq_levels[5:0], fast_timer_irq_levels[7:0],
			byte_timer_irq_levels}),
		.grant   (arb_grant)
	);

	assign next_irq_grant = arb_grant;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			byte_timer_irq_levels <= LEVELS_RESET;
			fast_timer_irq_levels <= LEVELS_RESET;
			time_base_irq_levels  <= LEVELS_RESET;
			sfr_rdata             <= 16'h0000;
			irq_grant             <= '0;
		end else begin
			byte_timer_irq_levels <= next_byte_timer_irq_levels;
			fast_timer_irq_levels <= next_fast_timer_irq_levels;
			time_base_irq_levels  <= next_time_base_irq_levels;
			sfr_rdata             <= next_sfr_rdata;
			irq_grant             <= next_irq_grant;
		end
	end

endmodule

`default_nettype wire

// >>> tb/level_props.sv
`timescale 1ns/1ps
`default_nettype none
module level_props
	import irq_level_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire sfr_req_t    sfr_req,
	input wire logic        level_control_enable,
	input wire logic [7:0]  byte_timer_irq,
	input wire logic [3:0]  wide_timer_irq,
	input wire logic [2:0]  slow_tick_irq,
	input wire logic [15:0] sfr_rdata,
	input wire logic [15:0] byte_timer_irq_levels,
	input wire logic [15:0] fast_timer_irq_levels,
	input wire logic [15:0] time_base_irq_levels,
	input wire irq_grant_t  irq_grant
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence s_bwr;
		sfr_req.wr && level_control_enable && sfr_req.addr == BYTE_TIMER_LEVELS_ADDR;
	endsequence
	chk_wr_locked:
		assert property (!level_control_enable |=> $stable({byte_timer_irq_levels,
			fast_timer_irq_levels, time_base_irq_levels})) else $error("locked write");
	chk_fast_upper:
		assert property (fast_timer_irq_levels[15:8] == 8'h00) else $error("fast upper");
	chk_tick_upper:
		assert property (time_base_irq_levels[15:6] == 10'h000) else $error("tick upper");
	chk_rd_idle:
		assert property (!sfr_req.rd |=> sfr_rdata == 16'h0000) else $error("rdata idle");
	chk_rd_fast:
		assert property (sfr_req.rd && sfr_req.addr == FAST_TIMER_LEVELS_ADDR
			|=> sfr_rdata == $past(fast_timer_irq_levels)) else $error("fast read");
	chk_bwr_full:
		assert property (s_bwr ##0 sfr_req.byte_en == 2'h3
			|=> byte_timer_irq_levels == $past(sfr_req.wdata)) else $error("full write");
	chk_bwr_high:
		assert property (s_bwr ##0 sfr_req.byte_en == 2'h2 |=> byte_timer_irq_levels ==
			{$past(sfr_req.wdata[15:8]), $past(byte_timer_irq_levels[7:0])}) else $error("hi");
	chk_grant_idle:
		assert property (!(|{byte_timer_irq, wide_timer_irq, slow_tick_irq})
			|=> !irq_grant.valid) else $error("idle grant");
	chk_grant_top:
		assert property (byte_timer_irq[0] && byte_timer_irq_levels[1:0] == 2'h3
			|=> irq_grant.valid && irq_grant.src == 4'h0) else $error("top grant");
endmodule
bind timer_irq_priority_levels level_props level_props_i (.*);
`default_nettype wire

// >>> tb/timer_irq_priority_levels_tb.sv
`timescale 1ns/1ps
`default_nettype none
module timer_irq_priority_levels_tb
	import irq_level_pkg::*;
;
	logic ref_clk = 0, rst = 1, level_control_enable = 0;
	sfr_req_t sfr_req = '0;
	logic [7:0] byte_timer_irq = 0;
	logic [3:0] wide_timer_irq = 0;
	logic [2:0] slow_tick_irq = 0;
	logic [15:0] sfr_rdata, byte_timer_irq_levels, fast_timer_irq_levels, time_base_irq_levels;
	irq_grant_t irq_grant;
	int err_count = 0, comparisons = 0, cyc = 0;
	timer_irq_priority_levels timer_irq_priority_levels_i (.*);
	always #4 ref_clk = ~ref_clk;
	task chk(string n, logic [15:0] s, logic [15:0] e);
		comparisons++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED %s exp %h seen %h", n, e, s);
		end
	endtask
	task wr(logic [15:0] a, logic [1:0] b, logic [15:0] d);
		@(posedge ref_clk) sfr_req <= '{1'b1, 1'b0, a, b, d};
		@(posedge ref_clk) sfr_req.wr <= 0;
	endtask
	task rd(logic [15:0] a, logic [15:0] e);
		@(posedge ref_clk) sfr_req <= '{1'b0, 1'b1, a, 2'h3, 16'h0000};
		@(posedge ref_clk) sfr_req.rd <= 0;
		#1 chk("rdata", sfr_rdata, e);
	endtask
	task grant(logic [7:0] b, logic [3:0] w, logic [2:0] t, logic [3:0] s, logic [1:0] l);
		@(posedge ref_clk) byte_timer_irq <= b;
		wide_timer_irq <= w;
		slow_tick_irq <= t;
		@(posedge ref_clk) #1 chk("grant", {9'h0, irq_grant}, {9'h0, 1'b1, s, l});
	endtask
	task end_sim;
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge ref_clk) if (++cyc > 500) begin
		err_count++;
		end_sim;
	end
	initial begin
		repeat (10) @(posedge ref_clk);
		rst <= 0;
		rd(BYTE_TIMER_LEVELS_ADDR, 16'h0000);
		rd(TIME_BASE_LEVELS_ADDR, 16'h0000);
		rd(16'hf032, 16'h0000);
		wr(FAST_TIMER_LEVELS_ADDR, 2'h3, 16'hffff);
		rd(FAST_TIMER_LEVELS_ADDR, 16'h0000);
		@(posedge ref_clk) level_control_enable <= 1;
		wr(BYTE_TIMER_LEVELS_ADDR, 2'h3, 16'hffff);
		wr(FAST_TIMER_LEVELS_ADDR, 2'h3, 16'hffff);
		wr(TIME_BASE_LEVELS_ADDR, 2'h3, 16'hffff);
		rd(BYTE_TIMER_LEVELS_ADDR, 16'hffff);
		rd(FAST_TIMER_LEVELS_ADDR, 16'h00ff);
		rd(TIME_BASE_LEVELS_ADDR, 16'h003f);
		wr(BYTE_TIMER_LEVELS_ADDR, 2'h2, 16'h1200);
		wr(BYTE_TIMER_LEVELS_ADDR, 2'h1, 16'h0043);
		rd(BYTE_TIMER_LEVELS_ADDR, 16'h1243);
		grant(8'h09, 4'h3, 3'h0, 4'h0, 2'h3);
		grant(8'h08, 4'h0, 3'h0, 4'h3, 2'h1);
		grant(8'h08, 4'h2, 3'h0, 4'h9, 2'h3);
		grant(8'h08, 4'h0, 3'h4, 4'he, 2'h3);
		grant(8'h01, 4'h0, 3'h1, 4'h0, 2'h3);
		end_sim;
	end
endmodule
`default_nettype wire
